// ===== rtl/hwlu_pkg.sv
// Package of constants and types for the halfword and word load unit.
package hwlu_pkg;
  localparam int DATA_W = 32;
  localparam int CAUSE_W = 5;
  localparam int REG_NUM_W = 5;
  localparam int IMM_W = 16;
  localparam logic [4:0] CAUSE_TLB_MISS = 5'h12;
  localparam logic [4:0] CAUSE_STORAGE = 5'h10;
  localparam logic [4:0] CAUSE_UNALIGNED = 5'h01;
  localparam logic [4:0] CAUSE_NONE = 5'h00;
  localparam logic [1:0] WORD_ALIGN_MASK = 2'h3;
  localparam int AREA_OPT_FAST = 0;
  localparam int AREA_OPT_SMALL = 1;
  localparam int AREA_OPT_FREQ = 2;
  localparam int LAT_SHORT = 1;
  localparam int LAT_LONG = 2;
  localparam int EXT_ADDR_MIN = 33;
  localparam int WIDE_ADDR_W = 2 * DATA_W;
  // Interrupt status bit positions.
  localparam int IRQ_BIT_TLB = 0;
  localparam int IRQ_BIT_STORAGE = 1;
  localparam int IRQ_BIT_ALIGN = 2;
  localparam int IRQ_BIT_ILLEGAL = 3;
  localparam int IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  // Register port offsets.
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h0;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h4;
  localparam logic [3:0] OFS_EXC_STATE = 4'h8;
  localparam logic [3:0] OFS_MACHINE = 4'hc;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    HWLU_SIZE_HALF = 2'h1,
    HWLU_SIZE_WORD = 2'h2
  } hwlu_size_type;

  typedef enum logic [2:0] {
    HWLU_ST_IDLE = 3'h1,
    HWLU_ST_WAIT = 3'h2,
    HWLU_ST_DONE = 3'h4
  } hwlu_state_type;
endpackage

// ===== rtl/hwlu_addr_gen.sv
// Address generation for the load unit: sum, immediate and concatenation.
module hwlu_addr_gen (
  // Operands
  input  wire logic [31:0] src_reg_first,
  input  wire logic [31:0] src_reg_second,
  input  wire logic [15:0] imm_field,
  input  wire logic [15:0] prefix_value,
  // Controls
  input  wire logic        use_imm,
  input  wire logic        prefix_valid,
  input  wire logic        extended_address_flag,
  // Result
  output logic      [63:0] addr_wide
);
  logic [31:0] operand;
  logic [31:0] sum;

  always_comb begin
    if (prefix_valid) begin
      operand = {prefix_value, imm_field};
    end else begin
      operand = {{16{imm_field[15]}}, imm_field};
    end
  end

  // Carry out of the top bit is dropped by the 32-bit target.
  assign sum = 32'(src_reg_first + (use_imm ? operand : src_reg_second));

  assign addr_wide = (extended_address_flag && !use_imm) ?
                     {src_reg_first, src_reg_second} :
                     {32'h0000_0000, sum};
endmodule

// ===== rtl/hwlu_byte_steer.sv
// Byte steering of fetched memory data into the destination layout.
module hwlu_byte_steer (
  // Fetched data, byte at the address in bits 31:24
  input  wire logic [31:0] mem_rdata,
  input  wire logic        is_word,
  input  wire logic        swap,
  // Result
  output logic      [31:0] load_data
);
  always_comb begin
    if (is_word) begin
      load_data = swap ?
        {mem_rdata[7:0], mem_rdata[15:8], mem_rdata[23:16],
         mem_rdata[31:24]} : mem_rdata;
    end else if (swap) begin
      load_data = {16'h0000, mem_rdata[23:16], mem_rdata[31:24]};
    end else begin
      load_data = {16'h0000, mem_rdata[31:16]};
    end
  end
endmodule

// ===== rtl/hwlu_load_unit.sv
// Load unit for unsigned halfword and word loads with exception checks.
// Function
// - Halfword load zero-fills upper destination half.
// - Reverse flag swaps the two halfword bytes.
// - Extended flag concatenates both sources as address.
// - Translation miss: cause, save and clear modes.
// - Zone fault in user virtual: storage exception.
// - Odd halfword address raises unaligned, size zero.
// - Unaligned word address raises unaligned, size one.
// - Priority miss, zone, alignment; one exception.
// - Halfword byte order follows mode, reverse, endian.
// - Destination unchanged whenever any exception occurs.
// - Immediate form adds sign-extended sixteen bit field.
// - Prefix supplies upper half of immediate operand.
// - Word load whole; reverse inverts four bytes.
// - One cycle, or two with area setting one.
// - Reverse variants valid only with reorder option.
// - Extended variants valid only beyond 32-bit addresses.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
module hwlu_load_unit #(
  parameter int area_optimisation_setting = hwlu_pkg::AREA_OPT_FAST,
  parameter int reorder_instr_option      = 1,
  parameter int addr_size                 = 32
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Pipeline request
  input  wire logic        req_valid,
  input  wire logic        req_is_word,
  input  wire logic        req_use_imm,
  input  wire logic        req_reverse,
  input  wire logic        req_ext_addr,
  input  wire logic [31:0] src_reg_first,
  input  wire logic [31:0] src_reg_second,
  input  wire logic [15:0] imm_field,
  input  wire logic        prefix_valid,
  input  wire logic [15:0] prefix_value,
  input  wire logic [4:0]  dest_reg_number,
  // Pipeline answer
  output logic             done_valid,
  output logic             dest_write,
  output logic      [4:0]  dest_number_out,
  output logic      [31:0] dest_data,
  output logic             illegal_instr,
  // Data memory and translation
  output logic      [63:0] mem_addr,
  output logic             mem_read,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        tlb_miss,
  input  wire logic        zone_blocked,
  input  wire logic        page_endian,
  // Machine state write
  input  wire logic        msr_write,
  input  wire logic        msr_user_in,
  input  wire logic        msr_virtual_in,
  output logic             user_mode_bit,
  output logic             virtual_mode_bit,
  output logic             user_mode_save,
  output logic             virtual_mode_save,
  // Exception state
  output logic      [4:0]  exception_cause,
  output logic             exc_store,
  output logic             exc_word,
  output logic             zone_fault_bit,
  output logic      [4:0]  dest_reg_number_alt,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  output logic             irq
);
  localparam int LAT = (area_optimisation_setting ==
                        hwlu_pkg::AREA_OPT_SMALL) ? hwlu_pkg::LAT_LONG
                                                  : hwlu_pkg::LAT_SHORT;
  localparam bit REORDER_OK = (reorder_instr_option == 1);
  localparam bit EXT_OK = (addr_size >= hwlu_pkg::EXT_ADDR_MIN);

  hwlu_pkg::hwlu_state_type state_reg;
  logic [63:0] addr_wide;
  logic [63:0] addr_reg;
  logic        word_reg;
  logic        rev_reg;
  logic [4:0]  rd_reg;
  logic [31:0] steered;
  logic        swap;
  logic        illegal;
  logic        miss_hit;
  logic        zone_hit;
  logic        align_hit;
  logic        any_exc;
  logic        finish;
  logic [hwlu_pkg::IRQ_W-1:0] irq_status_reg;
  logic [hwlu_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [hwlu_pkg::IRQ_W-1:0] irq_events;

  // All checks below run on the core clock and pause during reset.
  default clocking cb_core @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  hwlu_addr_gen u_addr (
    .src_reg_first         (src_reg_first),
    .src_reg_second        (src_reg_second),
    .imm_field             (imm_field),
    .prefix_value          (prefix_value),
    .use_imm               (req_use_imm),
    .prefix_valid          (prefix_valid),
    .extended_address_flag (req_ext_addr),
    .addr_wide             (addr_wide)
  );

  // Reverse and extended forms are refused unless configured in.
  assign illegal = req_valid && !req_use_imm &&
                   ((req_reverse && !REORDER_OK) ||
                    (req_ext_addr && !EXT_OK));

  // Capture the request; in the two-cycle setting it waits one cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= hwlu_pkg::HWLU_ST_IDLE;
    end else begin
      case (state_reg)
        hwlu_pkg::HWLU_ST_IDLE: begin
          if (req_valid && !illegal) begin
            state_reg <= (LAT == hwlu_pkg::LAT_LONG) ?
                         hwlu_pkg::HWLU_ST_WAIT :
                         hwlu_pkg::HWLU_ST_DONE;
          end
        end
        hwlu_pkg::HWLU_ST_WAIT: state_reg <= hwlu_pkg::HWLU_ST_DONE;
        hwlu_pkg::HWLU_ST_DONE: state_reg <= hwlu_pkg::HWLU_ST_IDLE;
        default:                state_reg <= hwlu_pkg::HWLU_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= 64'h0000_0000_0000_0000;
      word_reg <= 1'b0;
      rev_reg  <= 1'b0;
      rd_reg   <= 5'h00;
    end else if (state_reg == hwlu_pkg::HWLU_ST_IDLE && req_valid) begin
      addr_reg <= addr_wide;
      word_reg <= req_is_word;
      rev_reg  <= req_reverse && !req_use_imm;
      rd_reg   <= dest_reg_number;
    end
  end

  assign finish   = (state_reg == hwlu_pkg::HWLU_ST_DONE);
  assign mem_addr = addr_reg;
  assign mem_read = finish;

  // Checks in strict priority; later ones are masked by earlier ones.
  assign miss_hit  = finish && tlb_miss && virtual_mode_bit;
  assign zone_hit  = finish && !miss_hit && zone_blocked &&
                     user_mode_bit && virtual_mode_bit;
  assign align_hit = finish && !miss_hit && !zone_hit &&
                     (word_reg ? (addr_reg[1:0] != 2'h0)
                               : addr_reg[0]);
  assign any_exc   = miss_hit || zone_hit || align_hit;

  // Byte 0 at the address sits in bits 31:24 of the fetched data.
  assign swap = word_reg ? rev_reg :
                !((!virtual_mode_bit && rev_reg) ||
                  (virtual_mode_bit && rev_reg && page_endian) ||
                  (virtual_mode_bit && !rev_reg && !page_endian));

  hwlu_byte_steer u_steer (
    .mem_rdata (mem_rdata),
    .is_word   (word_reg),
    .swap      (swap),
    .load_data (steered)
  );

  // The destination write is held back on any exception.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_valid      <= 1'b0;
      dest_write      <= 1'b0;
      dest_number_out <= 5'h00;
      dest_data       <= hwlu_pkg::REG_RESET;
      illegal_instr   <= 1'b0;
    end else begin
      done_valid    <= finish;
      dest_write    <= finish && !any_exc;
      illegal_instr <= illegal;
      if (finish && !any_exc) begin
        dest_number_out <= rd_reg;
        dest_data       <= steered;
      end
    end
  end

  // Mode bits: software writes them; translation and zone faults save then clear them.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      user_mode_bit     <= 1'b0;
      virtual_mode_bit  <= 1'b0;
      user_mode_save    <= 1'b0;
      virtual_mode_save <= 1'b0;
    end else if (miss_hit || zone_hit) begin
      user_mode_save    <= user_mode_bit;
      virtual_mode_save <= virtual_mode_bit;
      user_mode_bit     <= 1'b0;
      virtual_mode_bit  <= 1'b0;
    end else if (msr_write) begin
      user_mode_bit    <= msr_user_in;
      virtual_mode_bit <= msr_virtual_in;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exception_cause     <= hwlu_pkg::CAUSE_NONE;
      exc_store           <= 1'b0;
      exc_word            <= 1'b0;
      zone_fault_bit      <= 1'b0;
      dest_reg_number_alt <= 5'h00;
    end else if (miss_hit) begin
      exception_cause <= hwlu_pkg::CAUSE_TLB_MISS;
      exc_store       <= 1'b0;
    end else if (zone_hit) begin
      exception_cause <= hwlu_pkg::CAUSE_STORAGE;
      exc_store       <= 1'b0;
      zone_fault_bit  <= 1'b1;
    end else if (align_hit) begin
      exception_cause     <= hwlu_pkg::CAUSE_UNALIGNED;
      exc_store           <= 1'b0;
      exc_word            <= word_reg;
      dest_reg_number_alt <= rd_reg;
    end
  end

  // Sticky event bits; a new event wins over a clear in the same cycle.
  assign irq_events = {illegal, align_hit, zone_hit, miss_hit};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= hwlu_pkg::IRQ_RESET;
      irq_mask_reg   <= hwlu_pkg::IRQ_RESET;
    end else begin
      if (reg_write && reg_addr == hwlu_pkg::OFS_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata[hwlu_pkg::IRQ_W-1:0];
      end
      if (reg_write && reg_addr == hwlu_pkg::OFS_IRQ_STATUS) begin
        irq_status_reg <= (irq_status_reg &
                           ~reg_wdata[hwlu_pkg::IRQ_W-1:0]) | irq_events;
      end else begin
        irq_status_reg <= irq_status_reg | irq_events;
      end
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= hwlu_pkg::REG_RESET;
    end else if (reg_read) begin
      case (reg_addr)
        hwlu_pkg::OFS_IRQ_STATUS:
          reg_rdata <= {28'h000_0000, irq_status_reg};
        hwlu_pkg::OFS_IRQ_MASK:
          reg_rdata <= {28'h000_0000, irq_mask_reg};
        hwlu_pkg::OFS_EXC_STATE:
          reg_rdata <= {19'h0_0000, dest_reg_number_alt, zone_fault_bit,
                        exc_word, exc_store, exception_cause};
        hwlu_pkg::OFS_MACHINE:
          reg_rdata <= {28'h000_0000, virtual_mode_save, user_mode_save,
                        virtual_mode_bit, user_mode_bit};
        default: reg_rdata <= hwlu_pkg::REG_RESET;
      endcase
    end else begin
      reg_rdata <= hwlu_pkg::REG_RESET;
    end
  end

  // Checks on the exception and latency behaviour.
  sequence s_req_taken;
    state_reg == hwlu_pkg::HWLU_ST_IDLE && req_valid && !illegal;
  endsequence

  AST_LATENCY: assert property (
    s_req_taken |-> ##LAT finish)
    else $error("Load did not finish at the configured latency.");

  AST_MISS_CAUSE: assert property (
    miss_hit |=> exception_cause == 5'h12 && !exc_store &&
                 !user_mode_bit && !virtual_mode_bit &&
                 virtual_mode_save)
    else $error("Translation miss state is wrong.");

  AST_ZONE_CAUSE: assert property (
    zone_hit |=> exception_cause == 5'h10 && zone_fault_bit &&
                 user_mode_save && virtual_mode_save)
    else $error("Zone fault state is wrong.");

  AST_HALF_ALIGN: assert property (
    finish && !word_reg && addr_reg[0] && !tlb_miss && !zone_blocked
    |=> exception_cause == 5'h01 && !exc_word && !dest_write)
    else $error("Odd halfword address not flagged.");

  AST_WORD_ALIGN: assert property (
    align_hit && word_reg |=> exc_word && dest_reg_number_alt == $past(rd_reg))
    else $error("Unaligned word not recorded.");

  AST_PRIORITY: assert property (
    finish && tlb_miss && virtual_mode_bit |=> exception_cause == 5'h12)
    else $error("Translation miss did not take priority.");

  AST_HOLD_DEST: assert property (
    finish && any_exc |=> !dest_write && $stable(dest_data))
    else $error("Destination changed on an exception.");

  AST_ZERO_FILL: assert property (
    dest_write && !$past(word_reg) |-> dest_data[31:16] == 16'h0000)
    else $error("Halfword load upper half not zero.");

  AST_ILLEGAL: assert property (
    illegal |=> illegal_instr && state_reg == hwlu_pkg::HWLU_ST_IDLE)
    else $error("Unsupported variant was not refused.");

  // A translation or zone fault leaves both mode bits cleared and the virtual bit saved.
  sequence s_mode_fault;
    miss_hit || zone_hit;
  endsequence

  sequence s_modes_saved;
    !user_mode_bit && !virtual_mode_bit && virtual_mode_save;
  endsequence

  AST_MODE_SAVE: assert property (
    s_mode_fault |=> s_modes_saved)
    else $error("Mode bits were not saved and cleared on a fault.");

  AST_EXT_ADDR: assert property (
    s_req_taken ##0 (req_ext_addr && !req_use_imm)
    |=> addr_reg == {$past(src_reg_first), $past(src_reg_second)})
    else $error("Extended address was not the two sources joined.");

  AST_ALIGN_RECORD: assert property (
    align_hit |=> exception_cause == hwlu_pkg::CAUSE_UNALIGNED &&
                  !exc_store && dest_reg_number_alt == $past(rd_reg))
    else $error("Unaligned access fields were not recorded.");

  AST_HALF_ORDER: assert property (
    finish && !any_exc && !word_reg && !virtual_mode_bit && rev_reg
    |=> dest_data == {16'h0000, $past(mem_rdata[31:16])})
    else $error("Halfword bytes were not in address order.");

  AST_WORD_DATA: assert property (
    finish && !any_exc && word_reg && !rev_reg
    |=> dest_data == $past(mem_rdata))
    else $error("Word load did not keep the fetched byte order.");
endmodule

// ===== sim/hwlu_mem_model.sv
// Behavioural data memory and translation buffer beside the load unit.
module hwlu_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Load unit side
  input  wire logic [63:0] mem_addr,
  input  wire logic        mem_read,
  output logic      [31:0] mem_rdata,
  output logic             tlb_miss,
  output logic             zone_blocked,
  output logic             page_endian,
  // Scenario controls
  input  wire logic        miss_cfg,
  input  wire logic        zone_cfg,
  input  wire logic        endian_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [34:0] last_reg;
  logic [34:0] live;

  function automatic logic [7:0] mb(input logic [63:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction

  assign live = {miss_cfg, zone_cfg, endian_cfg, mb(mem_addr),
                 mb(mem_addr + 64'h1), mb(mem_addr + 64'h2),
                 mb(mem_addr + 64'h3)};

  // Outside a read the lines carry the inverse of the last answer, so a
  // design that samples in the wrong cycle sees junk, not a stale match.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_reg <= 35'h0;
    end else if (mem_read) begin
      last_reg <= live;
    end
  end

  assign {tlb_miss, zone_blocked, page_endian, mem_rdata} =
    mem_read ? live : ~last_reg;
endmodule

// ===== sim/hwlu_load_unit_tb.sv
// Self-checking bench for the halfword and word load unit.
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module hwlu_load_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAT = hwlu_pkg::LAT_LONG;
  logic clk = '0, rst_n = '0, req_valid = '0, req_is_word = '0;
  logic req_use_imm = '0, req_reverse = '0, req_ext_addr = '0;
  logic prefix_valid = '0, msr_write = '0, msr_user_in = '0;
  logic msr_virtual_in = '0, reg_write = '0, reg_read = '0;
  logic miss_cfg = '0, zone_cfg = '0, endian_cfg = '0;
  logic [31:0] src_reg_first = '0, src_reg_second = '0, reg_wdata = '0;
  logic [15:0] imm_field = '0, prefix_value = '0;
  logic [4:0]  dest_reg_number = '0;
  logic [3:0]  reg_addr = '0;
  logic        done_valid, dest_write, illegal_instr, mem_read, tlb_miss;
  logic        zone_blocked, page_endian, user_mode_bit, virtual_mode_bit;
  logic        user_mode_save, virtual_mode_save, exc_store, exc_word;
  logic        zone_fault_bit, irq;
  logic [4:0]  dest_number_out, exception_cause, dest_reg_number_alt;
  logic [31:0] dest_data, mem_rdata, reg_rdata, prev;
  logic [63:0] mem_addr;
  int          err_count = 0, checked = 0;
  logic        done_min, illegal_min;

  always #12.5 clk = ~clk;

  hwlu_load_unit #(.area_optimisation_setting(hwlu_pkg::AREA_OPT_SMALL),
    .reorder_instr_option(1), .addr_size(64)) u_dut (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_is_word(req_is_word), .req_use_imm(req_use_imm),
    .req_reverse(req_reverse), .req_ext_addr(req_ext_addr),
    .src_reg_first(src_reg_first), .src_reg_second(src_reg_second),
    .imm_field(imm_field), .prefix_valid(prefix_valid),
    .prefix_value(prefix_value), .dest_reg_number(dest_reg_number),
    .done_valid(done_valid), .dest_write(dest_write),
    .dest_number_out(dest_number_out), .dest_data(dest_data),
    .illegal_instr(illegal_instr), .mem_addr(mem_addr),
    .mem_read(mem_read), .mem_rdata(mem_rdata), .tlb_miss(tlb_miss),
    .zone_blocked(zone_blocked), .page_endian(page_endian),
    .msr_write(msr_write), .msr_user_in(msr_user_in),
    .msr_virtual_in(msr_virtual_in), .user_mode_bit(user_mode_bit),
    .virtual_mode_bit(virtual_mode_bit), .user_mode_save(user_mode_save),
    .virtual_mode_save(virtual_mode_save),
    .exception_cause(exception_cause), .exc_store(exc_store),
    .exc_word(exc_word), .zone_fault_bit(zone_fault_bit),
    .dest_reg_number_alt(dest_reg_number_alt), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq));

  hwlu_mem_model u_mem (
    .clk(clk), .rst_n(rst_n), .mem_addr(mem_addr), .mem_read(mem_read),
    .mem_rdata(mem_rdata), .tlb_miss(tlb_miss),
    .zone_blocked(zone_blocked), .page_endian(page_endian),
    .miss_cfg(miss_cfg), .zone_cfg(zone_cfg), .endian_cfg(endian_cfg));

  // A second unit in the one-cycle setting without reorder or wide
  // addresses. The memory lines only answer the first unit, so only its
  // latency and its refusals are compared.
  hwlu_load_unit #(.area_optimisation_setting(hwlu_pkg::AREA_OPT_FAST),
    .reorder_instr_option(0), .addr_size(32)) u_dut_min (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_is_word(req_is_word), .req_use_imm(req_use_imm),
    .req_reverse(req_reverse), .req_ext_addr(req_ext_addr),
    .src_reg_first(src_reg_first), .src_reg_second(src_reg_second),
    .imm_field(imm_field), .prefix_valid(prefix_valid),
    .prefix_value(prefix_value), .dest_reg_number(dest_reg_number),
    .done_valid(done_min), .dest_write(), .dest_number_out(),
    .dest_data(), .illegal_instr(illegal_min), .mem_addr(), .mem_read(),
    .mem_rdata(mem_rdata), .tlb_miss(tlb_miss),
    .zone_blocked(zone_blocked), .page_endian(page_endian),
    .msr_write(msr_write), .msr_user_in(msr_user_in),
    .msr_virtual_in(msr_virtual_in), .user_mode_bit(),
    .virtual_mode_bit(), .user_mode_save(), .virtual_mode_save(),
    .exception_cause(), .exc_store(), .exc_word(), .zone_fault_bit(),
    .dest_reg_number_alt(), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(), .irq());

  function automatic logic [7:0] mb(input logic [31:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction

  // Halfword result; k set means the byte at the address lands high.
  function automatic logic [31:0] hw(input logic [31:0] a, input logic k);
    return k ? {16'h0000, mb(a), mb(a + 32'h1)}
             : {16'h0000, mb(a + 32'h1), mb(a)};
  endfunction

  function automatic logic [31:0] wd(input logic [31:0] a, input logic r);
    return r ? {mb(a + 32'h3), mb(a + 32'h2), mb(a + 32'h1), mb(a)}
             : {mb(a), mb(a + 32'h1), mb(a + 32'h2), mb(a + 32'h3)};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    `CHK(reg_rdata, e)
  endtask

  task automatic md(input logic u, input logic v);
    @(posedge clk);
    msr_write <= 1'b1;
    msr_user_in <= u;
    msr_virtual_in <= v;
    @(posedge clk);
    msr_write <= 1'b0;
  endtask

  // One load; ok says whether the destination must be written with ed.
  task automatic ld(input logic w, m, r, x, input logic [31:0] a, b,
      input logic [15:0] im, p, input logic pv, input logic [63:0] ea,
      input logic ok, input logic [31:0] ed);
    int n;
    int rn;
    @(posedge clk);
    req_valid <= 1'b1;
    req_is_word <= w;
    req_use_imm <= m;
    req_reverse <= r;
    req_ext_addr <= x;
    src_reg_first <= a;
    src_reg_second <= b;
    imm_field <= im;
    prefix_value <= p;
    prefix_valid <= pv;
    dest_reg_number <= dest_reg_number + 5'h1;
    @(posedge clk);
    req_valid <= 1'b0;
    prefix_valid <= 1'b0;
    n = 0;
    rn = 0;
    while (done_valid !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
      if (n == 1) `CHK(illegal_min, !m && (r || x))
      if (n == 2) `CHK(done_min, !(!m && (r || x)))
      if (mem_read === 1'b1) begin
        rn = n;
        `CHK(mem_addr, ea)
      end
    end
    `CHK(n, LAT + 1)
    `CHK(rn, LAT)
    `CHK(dest_write, ok)
    if (ok) prev = ed;
    `CHK(dest_data, prev)
    if (ok) `CHK(dest_number_out, dest_reg_number)
  endtask

  initial begin
    #200000;
    err_count++;
    close_out();
  end

  initial begin
    logic [31:0] ad;
    logic k;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i += 4) rd(i[3:0], 32'h0000_0000);
    rd(4'h1, 32'h0000_0000);
    // Every virtual mode, reverse and endian combination of the halfword form, user mode off.
    for (int i = 0; i < 8; i++) begin
      md(1'b0, i[2]);
      endian_cfg <= i[0];
      ad = 32'h0000_1022 + 32'(2 * i);
      k = (!i[2] && i[1]) || (i[2] && i[1] && i[0]) ||
          (i[2] && !i[1] && !i[0]);
      ld(0, 0, i[1], 0, 32'h0000_1000, ad - 32'h1000, 16'h0, 16'h0, 0,
         {32'h0, ad}, 1, hw(ad, k));
    end
    for (int r = 0; r < 2; r++)
      ld(1, 0, r[0], 1, 32'h0000_00ab, 32'h0000_0040, 16'h0, 16'h0, 0,
         64'h0000_00ab_0000_0040, 1, wd(32'h40, r[0]));
    ld(1, 0, 0, 0, 32'hffff_fff0, 32'h0000_0014, 16'h0, 16'h0, 0,
       64'h4, 1, wd(32'h4, 0));
    ld(0, 1, 0, 0, 32'h0000_0100, 32'h0000_0500, 16'hfffe, 16'h0, 0,
       64'hfe, 1, hw(32'hfe, 0));
    ld(0, 1, 0, 0, 32'h0000_0100, 32'h0000_0500, 16'h0002, 16'h0001, 1,
       64'h0001_0102, 1, hw(32'h0001_0102, 0));
    md(1'b1, 1'b1);
    miss_cfg <= 1'b1;
    zone_cfg <= 1'b1;
    ld(0, 0, 0, 0, 32'h1, 32'h0, 16'h0, 16'h0, 0, 64'h1, 0, 0);
    `CHK(exception_cause, hwlu_pkg::CAUSE_TLB_MISS)
    `CHK({exc_store, zone_fault_bit, user_mode_bit, virtual_mode_bit,
          user_mode_save, virtual_mode_save}, 6'h03)
    rd(4'hc, 32'h0000_000c);
    md(1'b1, 1'b1);
    miss_cfg <= 1'b0;
    ld(0, 0, 0, 0, 32'h3, 32'h0, 16'h0, 16'h0, 0, 64'h3, 0, 0);
    `CHK(exception_cause, hwlu_pkg::CAUSE_STORAGE)
    `CHK({exc_store, zone_fault_bit, user_mode_bit, virtual_mode_bit,
          user_mode_save, virtual_mode_save}, 6'h13)
    md(1'b0, 1'b1);
    ld(0, 0, 0, 0, 32'h10, 32'h0, 16'h0, 16'h0, 0, 64'h10, 1,
       hw(32'h10, 0));
    md(1'b0, 1'b0);
    miss_cfg <= 1'b1;
    ld(1, 0, 0, 0, 32'h20, 32'h0, 16'h0, 16'h0, 0, 64'h20, 1,
       wd(32'h20, 0));
    miss_cfg <= 1'b0;
    zone_cfg <= 1'b0;
    ld(0, 0, 1, 0, 32'h11, 32'h0, 16'h0, 16'h0, 0, 64'h11, 0, 0);
    `CHK({exception_cause, exc_word, exc_store},
         {hwlu_pkg::CAUSE_UNALIGNED, 2'h0})
    `CHK(dest_reg_number_alt, dest_reg_number)
    for (int j = 1; j < 3; j++) begin
      ad = 32'h40 + 32'(j);
      ld(1, 0, 0, 0, ad, 32'h0, 16'h0, 16'h0, 0, {32'h0, ad}, 0, 0);
      `CHK({exception_cause, exc_word, exc_store},
           {hwlu_pkg::CAUSE_UNALIGNED, 2'h2})
      rd(4'h8, {19'h0, dest_reg_number, 8'hc1});
    end
    rd(4'h0, 32'h0000_0007);
    `CHK(irq, 1'b0)
    wr(4'h4, 32'h0000_0004);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b1)
    wr(4'h0, 32'h0000_0004);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    rd(4'h0, 32'h0000_0003);
    rd(4'h4, 32'h0000_0004);
    close_out();
  end
endmodule
